/* shared/lane_strobe_pkg.sv */
package lane_strobe_pkg;
    // strobe timing: one oscillator period equals one ref clock cycle
    localparam int unsigned TOSC_NS           = 5;
    localparam int unsigned CLK_PERIOD_NS     = 5;
    localparam int unsigned TOSC_CYCLES       =
        (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  LANE_PULSE_CYCLES = 4'h2 * TOSC_CYCLES[3:0];
    localparam logic [3:0]  LONG_PULSE_CYCLES =
        LANE_PULSE_CYCLES + TOSC_CYCLES[3:0];
    localparam logic [3:0]  SETUP_CYCLES      = 4'h1;
    localparam int unsigned ADDR_BIT_LSB      = 0;
endpackage

/* src/lane_strobe_ctrl.sv */
//Function
// - low strobe: word writes, even byte writes
// - high strobe: word writes, odd byte writes
// - 16-bit reads fetch even word, drop byte
// - 8-bit bus: byte access, low strobe always
// - 8-bit word: two byte cycles
// - long strobe on low pin, 16-bit only
// - long strobe one period longer
// - upper-lane enable low when upper byte used, long strobe mode only
// - addr bit0 low enables lower lane
// - width pin sampled after address strobe
// - setup bit zero forces 8-bit bus
`timescale 1ns/10ps
module lane_strobe_ctrl
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_req_valid,
    input  wire logic        i_req_write,
    input  wire logic        i_req_word,
    input  wire logic        i_long_strobe_mode,
    input  wire logic [15:0] i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    input  wire logic        i_bus_width_select,
    input  wire logic        i_lane_size_pin,
    input  wire logic [15:0] i_bus_data_in,
    output logic             o_req_ready,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    output logic             o_address_strobe,
    output logic [15:0]      o_latched_addr_lines,
    output logic [15:0]      o_bus_data_out,
    output logic             o_bus_data_oe,
    output logic             o_read_n,
    output logic             o_store_strobe_low_lane_n,
    output logic             o_store_strobe_high_lane_n,
    output logic             o_upper_lane_enable_n
);

////////////////////////////////////////////////////////////////////////////
typedef enum logic [2:0]
{
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_STROBE = 3'b011,
    ST_DONE   = 3'b100
} bus_state_e;

bus_state_e  state_q;
logic [15:0] addr_q;
logic [15:0] wdata_q;
logic [15:0] rdata_q;
logic        write_q;
logic        word_q;
logic        long_q;
logic        wide_q;
logic        second_q;
logic [3:0]  cnt_q;
logic        pin_s1_q;
logic        pin_s2_q;
logic        low_n_q;
logic        high_n_q;
logic        rsp_q;

// width pin passes two flops before use
always_ff @(posedge i_ref_clk)
begin
    pin_s1_q <= i_lane_size_pin;
    pin_s2_q <= pin_s1_q;
end

////////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] even_addr(input logic [15:0] a);
    even_addr = {a[15:1], 1'b0};
endfunction

wire         wide_now   = i_bus_width_select & pin_s2_q;
wire         odd_byte   = addr_q[lane_strobe_pkg::ADDR_BIT_LSB];
wire         split      = ~wide_q & word_q;
wire         low_use    = wide_q ? (word_q | ~odd_byte) : 1'b1;
wire         high_use   = wide_q & (word_q | odd_byte);
wire         long_on    = long_q & wide_q;
wire [3:0]   pulse_len  = long_on ? lane_strobe_pkg::LONG_PULSE_CYCLES
                                  : lane_strobe_pkg::LANE_PULSE_CYCLES;
wire [15:0]  bus_addr   = wide_q ? (write_q ? addr_q : even_addr(addr_q))
                        : (second_q ? (addr_q | 16'h0001) : addr_q);
wire [7:0]   byte_in    = i_bus_data_in[7:0];
wire [7:0]   rd_sel     = odd_byte ? i_bus_data_in[15:8] : byte_in;

assign o_req_ready = (state_q == ST_IDLE);
assign o_rsp_valid = rsp_q;
assign o_rsp_rdata = rdata_q;
assign o_latched_addr_lines = bus_addr;

////////////////////////////////////////////////////////////////////////////
always_ff @(posedge i_ref_clk)
begin
    if (i_reset)
    begin
        state_q  <= ST_IDLE;
        addr_q   <= 16'h0000;
        wdata_q  <= 16'h0000;
        rdata_q  <= 16'h0000;
        write_q  <= 1'b0;
        word_q   <= 1'b0;
        long_q   <= 1'b0;
        wide_q   <= 1'b0;
        second_q <= 1'b0;
        cnt_q    <= 4'h0;
        rsp_q    <= 1'b0;
    end
    else
    begin
        rsp_q <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (i_req_valid)
                begin
                    addr_q   <= i_req_addr;
                    wdata_q  <= i_req_wdata;
                    write_q  <= i_req_write;
                    word_q   <= i_req_word;
                    long_q   <= i_long_strobe_mode;
                    second_q <= 1'b0;
                    wide_q   <= wide_now;
                    state_q  <= ST_ADDR;
                end
            end
            ST_ADDR:
                state_q <= ST_SAMPLE;
            ST_SAMPLE:
            begin
                if (!second_q)
                    wide_q <= wide_now;
                cnt_q   <= 4'h0;
                state_q <= ST_STROBE;
            end
            ST_STROBE:
            begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == pulse_len - 4'h1)
                begin
                    if (!write_q)
                    begin
                        if (wide_q && word_q)
                            rdata_q <= i_bus_data_in;
                        else if (wide_q)
                            rdata_q <= {8'h00, rd_sel};
                        else if (second_q)
                            rdata_q <= {byte_in, rdata_q[7:0]};
                        else
                            rdata_q <= {8'h00, byte_in};
                    end
                    state_q <= ST_DONE;
                end
            end
            ST_DONE:
            begin
                if (split && !second_q)
                begin
                    second_q <= 1'b1;
                    state_q  <= ST_ADDR;
                end
                else
                begin
                    rsp_q   <= 1'b1;
                    state_q <= ST_IDLE;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
wire strobing  = (state_q == ST_STROBE) & write_q;
wire lane_win  = strobing & (cnt_q < lane_strobe_pkg::LANE_PULSE_CYCLES);
wire long_win  = strobing & (cnt_q < lane_strobe_pkg::LONG_PULSE_CYCLES);
wire pin_low_d = long_on ? ~long_win : ~(lane_win & low_use);
wire in_cycle  = (state_q == ST_STROBE);
wire bhe_d     = ~(in_cycle & high_use);
wire hi_d      = long_on ? bhe_d : ~(lane_win & high_use);

always_ff @(posedge i_ref_clk)
begin
    if (i_reset)
    begin
        low_n_q  <= 1'b1;
        high_n_q <= 1'b1;
    end
    else
    begin
        low_n_q  <= pin_low_d;
        high_n_q <= hi_d;
    end
end

assign o_store_strobe_low_lane_n  = low_n_q;
assign o_store_strobe_high_lane_n = high_n_q;
assign o_upper_lane_enable_n      = long_on ? high_n_q : 1'b1;
assign o_address_strobe = (state_q == ST_ADDR);
assign o_read_n         = ~((state_q == ST_STROBE) & ~write_q);
assign o_bus_data_oe    = (state_q == ST_STROBE) & write_q;
assign o_bus_data_out   = wide_q ? wdata_q
                        : (second_q ? {8'h00, wdata_q[15:8]}
                                    : {8'h00, (word_q | ~odd_byte)
                                              ? wdata_q[7:0]
                                              : wdata_q[15:8]});

////////////////////////////////////////////////////////////////////////////
a_low_strobe_even: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_STROBE && write_q && cnt_q == 4'h0 && wide_q && !long_q
     && !word_q && odd_byte) |=> o_store_strobe_low_lane_n)
    else $error("low strobe on odd byte write");
a_high_strobe_odd: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_STROBE && write_q && cnt_q == 4'h0 && wide_q && !long_q
     && (word_q || odd_byte)) |=> !o_store_strobe_high_lane_n)
    else $error("high strobe missing");
a_narrow_high_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!wide_q && state_q == ST_STROBE) |=> o_store_strobe_high_lane_n)
    else $error("high strobe on 8-bit bus");
a_split_two_cycles: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_DONE && split && !second_q) |=> state_q == ST_ADDR
     ##1 second_q)
    else $error("word not split");
a_long_pulse_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_SAMPLE ##1 state_q == ST_STROBE && long_on && write_q)
    |=> !o_store_strobe_low_lane_n [*3] ##1 o_store_strobe_low_lane_n)
    else $error("long strobe length");
a_read_even_word: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_STROBE && !write_q && wide_q)
    |-> !o_latched_addr_lines[0])
    else $error("wide read not even");
a_width_forced: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_q == ST_SAMPLE && !second_q && !i_bus_width_select)
    |=> !wide_q)
    else $error("width select ignored");
a_no_long_narrow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !wide_q |-> o_upper_lane_enable_n && o_store_strobe_high_lane_n)
    else $error("upper enable on narrow bus");

c_wide_write: cover property (@(posedge i_ref_clk)
    state_q == ST_STROBE && write_q && wide_q);
c_split_word: cover property (@(posedge i_ref_clk)
    state_q == ST_DONE && second_q);
c_long_write: cover property (@(posedge i_ref_clk)
    state_q == ST_STROBE && long_on);

endmodule

/* verif/ext_bus_glue.sv */
`timescale 1ns/10ps
module ext_bus_glue
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_byte_bus,
    input  wire logic        i_long,
    input  wire logic        i_address_strobe,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_data,
    input  wire logic        i_read_n,
    input  wire logic        i_lo_n,
    input  wire logic        i_hi_n,
    input  wire logic        i_ule_n,
    output logic      [15:0] o_data
);
    logic [7:0]  mem [256];
    logic [15:0] addr_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [7:0]  ev;
    logic        we_lo;
    logic        we_hi;
    logic [15:0] port_q = 16'hffff;
    logic [15:0] pull_low;
    logic [15:0] port_pins;
    logic        io_hit;
    logic [15:0] rd_word;
    logic [7:0]  rd_byte;
    assign ev     = {addr_q[7:1], 1'b0};
    // port latch sits at the last two bytes below the 2000 boundary
    assign io_hit = (addr_q[15:1] == 15'h0fff);
    // open drain: a zero pulls the line low, a one lets the pull-up win
    assign pull_low  = ~port_q;
    assign port_pins = ~pull_low;
    assign rd_word = io_hit ? port_pins : {mem[ev | 8'h01], mem[ev]};
    assign rd_byte = !io_hit ? mem[addr_q[7:0]]
                   : (addr_q[0] ? port_pins[15:8] : port_pins[7:0]);
    assign we_lo  = i_long ? !i_lo_n && !addr_q[0] : !i_lo_n;
    assign we_hi  = i_long ? !i_lo_n && !i_ule_n : !i_hi_n;
    // released bus shows the inverse of its last value
    assign o_data = i_read_n ? ~last_q : i_byte_bus ?
        {~last_q[15:8], rd_byte} : rd_word;
    initial
    begin
        foreach (mem[j])
            mem[j] = 8'h00;
    end
    always @(posedge i_ref_clk)
    begin
        last_q <= o_data;
        if (i_reset)
            port_q <= 16'hffff;
        else if (io_hit && i_byte_bus && !i_lo_n)
            port_q <= addr_q[0] ? {i_data[7:0], port_q[7:0]}
                                : {port_q[15:8], i_data[7:0]};
        else if (io_hit && !i_byte_bus)
            port_q <= {we_hi ? i_data[15:8] : port_q[15:8],
                       we_lo ? i_data[7:0] : port_q[7:0]};
        if (i_address_strobe)
            addr_q <= i_addr;
        if (i_byte_bus && !i_lo_n)
            mem[addr_q[7:0]] <= i_data[7:0];
        if (!i_byte_bus && we_lo)
            mem[ev] <= i_data[7:0];
        if (!i_byte_bus && we_hi)
            mem[ev | 8'h01] <= i_data[15:8];
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        vld = 1'b0, wr = 1'b0, wd = 1'b0, lng = 1'b0;
    logic        sel = 1'b1, pin = 1'b1, k, ule_seen, bb_w;
    logic [15:0] adr = 16'h0000, wdat = 16'h0000, bus_in, a;
    logic        rdy, rsp, astb, oe, rd_n, lo_n, hi_n, ule_n;
    logic [15:0] rdat, la, dout, first_a, last_a;
    logic [7:0]  expmem [256];
    logic [7:0]  b;
    int          num_errors = 0, cmp_count = 0, lo_cnt, hi_cnt, ast_cnt, g;
    assign bb_w = !sel || !pin;
    lane_strobe_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_req_valid(vld), .i_req_write(wr), .i_req_word(wd),
        .i_long_strobe_mode(lng), .i_req_addr(adr), .i_req_wdata(wdat),
        .i_bus_width_select(sel), .i_lane_size_pin(pin),
        .i_bus_data_in(bus_in), .o_req_ready(rdy), .o_rsp_valid(rsp),
        .o_rsp_rdata(rdat), .o_address_strobe(astb),
        .o_latched_addr_lines(la), .o_bus_data_out(dout),
        .o_bus_data_oe(oe), .o_read_n(rd_n),
        .o_store_strobe_low_lane_n(lo_n), .o_store_strobe_high_lane_n(hi_n),
        .o_upper_lane_enable_n(ule_n));
    ext_bus_glue i_glue (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_byte_bus(bb_w),
        .i_long(lng), .i_address_strobe(astb), .i_addr(la), .i_data(dout),
        .i_read_n(rd_n), .i_lo_n(lo_n), .i_hi_n(hi_n), .i_ule_n(ule_n),
        .o_data(bus_in));
    initial
    begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
    begin
        lo_cnt = lo_cnt + int'(!lo_n);
        hi_cnt = hi_cnt + int'(!hi_n);
        if (!lo_n && !ule_n)
            ule_seen = 1'b1;
        if (astb && ast_cnt == 0)
            first_a = la;
        if (astb)
            last_a = la;
        ast_cnt = ast_cnt + int'(astb);
    end
    task automatic chk(input string nm, input logic [15:0] s, x);
        cmp_count++;
        if (s !== x)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic op(input logic w, kk, input logic [15:0] ad, d);
        int          n;
        logic        lg;
        logic [7:0]  ev;
        logic [15:0] lp, xlo, xr, xhi, xac, xso;
        lg = lng && !bb_w;
        ev = {ad[7:1], 1'b0};
        lp = 16'(lane_strobe_pkg::LANE_PULSE_CYCLES);
        {lo_cnt, hi_cnt, ast_cnt, ule_seen} = '0;
        {wr, wd, adr, wdat, vld} = {w, kk, ad, d, 1'b1};
        n = 0;
        while (!rdy && n < 20)
        begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        if (!rdy)
        begin
            num_errors++;
            conclude();
        end
        @(posedge i_ref_clk);
        #1 vld = 1'b0;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            #1 n++;
        end while (!rsp && n < 60);
        if (!rsp)
        begin
            num_errors++;
            conclude();
        end
        if (w)
            expmem[kk ? ev : ad[7:0]] = d[7:0];
        if (w && kk)
            expmem[ev | 8'h01] = d[15:8];
        xlo = (bb_w || kk || !ad[0]) ? lp : 16'h0000;
        xlo = (bb_w && kk) ? lp + lp : xlo;
        xlo = lg ? 16'(lane_strobe_pkg::LONG_PULSE_CYCLES) : xlo;
        xr = kk ? {expmem[ev | 8'h01], expmem[ev]} : {8'h00, expmem[ad[7:0]]};
        xhi = (w && !bb_w && (kk || ad[0])) ? lp : 16'h0000;
        xac = (bb_w && kk) ? 16'h0002 : 16'h0001;
        xso = {ev, ev | 8'h01};
        chk("low_strobe", 16'(lo_cnt), w ? xlo : 16'h0000);
        if (!lg)
            chk("high_strobe", 16'(hi_cnt), xhi);
        if (w && lg)
            chk("upper_enable", 16'(ule_seen), 16'(kk || ad[0]));
        chk("addr_cycles", 16'(ast_cnt), xac);
        if (bb_w && kk)
            chk("split_order", {first_a[7:0], last_a[7:0]}, xso);
        if (!w && !bb_w)
            chk("read_addr_bit0", 16'(first_a[0]), 16'h0000);
        if (!w)
            chk("read_data", kk ? rdat : {8'h00, rdat[7:0]}, xr);
    endtask
    initial
    begin
        void'($urandom(32'h77d1_3bff));
        foreach (expmem[j])
            expmem[j] = 8'h00;
        repeat (6) @(posedge i_ref_clk);
        #1 i_reset = 1'b0;
        for (int t = 0; t < 96; t++)
        begin
            g = (t < 32) ? t / 8 : int'($urandom_range(3, 0));
            sel = (t % 8 == 0) ? (g != 2) : sel;
            pin = (t % 8 == 0) ? (g != 3) : pin;
            lng = (t % 8 == 0) ? (g == 1) || (t >= 64) : lng;
            if (t % 8 == 0)
            begin
                repeat (3) @(posedge i_ref_clk);
                #1;
            end
            if (t == 48)
            begin
                i_reset = 1'b1;
                repeat (2) @(posedge i_ref_clk);
                #1 i_reset = 1'b0;
                chk("rst", {13'h0000, lo_n, hi_n, rdy}, 16'h0007);
                expmem[8'hfe] = 8'hff;
                expmem[8'hff] = 8'hff;
                op(1'b0, 1'b1, 16'h1ffe, 16'h0000);
            end
            k = 1'($urandom_range(1, 0));
            a = 16'($urandom());
            a = (t % 8 == 7) ? {8'h1f, 7'h7f, !k} : a;
            a[0] = a[0] && !k;
            b = 8'($urandom());
            op(1'b1, k, a, k ? 16'($urandom()) : {b, b});
            op(1'b0, k, a, 16'h0000);
            if (t % 8 == 7)
                $display("test group %0d done", t / 8);
        end
        conclude();
    end
endmodule
